// File: logic/atc_attr_ctrl.sv
// Attribute stage: shared index/data port, palette, mode control, pixel path
//
// Overview of operation
// - Status port read clears the access flip-flop to index selection.
// - Write after an index write stores into the indexed attribute register.
// - Flip-flop toggles on each 3C0h write; reads at 3C1h leave it.
// - 3C0h reads return the index; 3C1h reads return indexed data.
// - Index bits 4:0 pick the attribute register for data accesses.
// - Source bit clear blanks palette and video; set gives normal translation.
// - Indexes 00h-0Fh hold sixteen six-bit palette entries, top bits reserved.
// - Mode control sits at index 10h and resets to 00h.
// - Mode bit 7 takes colour bits 5:4 from colour select, else palette.
// - Panning reset forces panning zero from line compare until vsync.
// - Mode bit 3 picks blink instead of background intensity in text.
// - Line-graphics bit extends codes C0h-DFh into the ninth dot.
// - Mode bit 0 selects text or graphics attribute handling.
// - Status port bits 5:4 return two colour bits per the status mux.
`timescale 1ns/1ps
`include "atc_defs.svh"
module atc_attr_ctrl
    import atc_pkg::*;
(
    input  wire logic       core_clk_in,   // Dot clock, 20 MHz
    input  wire logic       rst_b_in,      // Async reset, active low
    input  wire logic [9:0] io_addr_in,    // Host I/O port address
    input  wire logic       io_wr_in,      // Write strobe, one cycle
    input  wire logic       io_rd_in,      // Read strobe, one cycle
    input  wire logic [7:0] io_wdata_in,   // Write data
    output logic      [7:0] io_rdata_out,  // Read data, next cycle
    input  wire logic [3:0] pix_idx_in,    // Graphics pixel nibble
    input  wire logic       glyph_dot_in,  // Text font dot
    input  wire logic       ninth_dot_in,  // Current dot is ninth column
    input  wire logic [7:0] char_code_in,  // Text character code
    input  wire logic [7:0] attr_byte_in,  // Text attribute byte
    input  wire logic       blink_on_in,   // Blink phase
    input  wire logic [3:0] colour_sel_in, // Colour select bits 3:0
    input  wire logic [1:0] stat_mux_in,   // Video status mux select
    input  wire logic [3:0] pan_in,        // Horizontal panning value
    input  wire logic       line_cmp_in,   // Line compare match pulse
    input  wire logic       vsync_in,      // Vertical sync level
    output logic      [7:0] colour_out,    // Colour to the DAC
    output logic            colour_vld_out,// Colour word valid
    output logic            video_en_out,  // Video outputs enabled
    output logic      [3:0] pan_out        // Effective panning
);
    // ==========================================================
    // Host port decode
    function automatic logic port_is(input logic [9:0] a,
                                     input logic [9:0] p);
        port_is = (a == p);
    endfunction : port_is

    function automatic logic is_line_gfx(input logic [7:0] c);
        is_line_gfx = (c >= `ATC_LGFX_FIRST) && (c <= `ATC_LGFX_LAST);
    endfunction : is_line_gfx

    atc_acc_t  acc_reg;
    atc_acc_t  acc_next;
    logic [7:0] index_reg;
    logic [7:0] mode_reg;
    logic [7:0] pal_reg [16];
    logic       wr_attr;
    logic       rd_index;
    logic       rd_data;
    logic       rd_stat;
    logic       data_wr;
    logic [4:0] sel;
    logic [7:0] sel_data;
    logic [7:0] stat_data;
    logic [7:0] rdata_next;

    assign wr_attr  = io_wr_in && port_is(io_addr_in, `ATC_PORT_ATTR_WR);
    assign rd_index = io_rd_in && port_is(io_addr_in, `ATC_PORT_ATTR_WR);
    assign rd_data  = io_rd_in && port_is(io_addr_in, `ATC_PORT_ATTR_RD);
    assign rd_stat  = io_rd_in &&
                      (port_is(io_addr_in, `ATC_PORT_STAT_MONO) ||
                       port_is(io_addr_in, `ATC_PORT_STAT_COLOUR));
    assign data_wr  = wr_attr && (acc_reg == ATC_ACC_DATA);
    assign sel      = index_reg[`ATC_IDX_BITS];

    // Status read wins over a write in the same cycle
    assign acc_next = rd_stat ? ATC_ACC_INDEX :
                      wr_attr ? atc_acc_t'(~acc_reg) : acc_reg;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acc_reg <= ATC_ACC_INDEX;
        end else begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            index_reg <= `ATC_IDX_RESET;
        end else if (wr_attr && acc_reg == ATC_ACC_INDEX) begin
            index_reg <= {2'b00, io_wdata_in[5:0]};
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_reg <= `ATC_MODE_RESET;
        end else if (data_wr && sel == `ATC_IDX_MODE) begin
            mode_reg <= io_wdata_in;
        end
    end

    // ==========================================================
    // Palette entries, no reset: contents are undefined at power-on
    generate
        for (genvar i = 0; i < 16; i++) begin : g_pal
            always_ff @(posedge core_clk_in) begin
                if (data_wr && sel == 5'(i)) begin
                    pal_reg[i] <= io_wdata_in & `ATC_PAL_MASK;
                end
            end
        end
    endgenerate

    assign sel_data = (sel[4] == 1'b0) ? pal_reg[sel[3:0]] :
                      (sel == `ATC_IDX_MODE) ? mode_reg : 8'h00;

    // ==========================================================
    // Status and read data
    logic [1:0] stat_bits;
    assign stat_bits = (stat_mux_in == 2'h0) ? {colour_out[2], colour_out[0]}
                     : (stat_mux_in == 2'h1) ? {colour_out[5], colour_out[4]}
                     : (stat_mux_in == 2'h2) ? {colour_out[3], colour_out[1]}
                     : {colour_out[7], colour_out[7]};
    assign stat_data = {2'b00, stat_bits, vsync_in, 3'b000};
    assign rdata_next = rd_index ? index_reg :
                        rd_data  ? sel_data  :
                        rd_stat  ? stat_data : io_rdata_out;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_rdata_out <= 8'h00;
        end else begin
            io_rdata_out <= rdata_next;
        end
    end

    // ==========================================================
    // Pixel path
    logic       pal_src_on;
    logic       fg_dot;
    logic       prev_dot_reg;
    logic [3:0] bg_idx;
    logic [3:0] txt_idx;
    logic [3:0] mono_idx;
    logic [3:0] pix_sel;
    logic [7:0] pal_col;
    logic [7:0] col_next;
    logic       half_reg;
    logic [3:0] nib_reg;
    logic       pan_zero_reg;

    assign pal_src_on = index_reg[`ATC_IDX_PAL_SRC];
    // Ninth dot copies the eighth only for line-graphics codes
    assign fg_dot = !ninth_dot_in ? glyph_dot_in :
                    (mode_reg[`ATC_MODE_LINE_GFX] &&
                     is_line_gfx(char_code_in)) ? prev_dot_reg : 1'b0;
    // Blink mode steals attribute bit 7 from background intensity
    assign bg_idx = mode_reg[`ATC_MODE_BLINK] ?
                    {1'b0, attr_byte_in[6:4]} : attr_byte_in[7:4];
    assign txt_idx = (fg_dot && !(mode_reg[`ATC_MODE_BLINK] &&
                      attr_byte_in[7] && blink_on_in)) ?
                     attr_byte_in[3:0] : bg_idx;
    assign mono_idx = !fg_dot ? 4'h0 :
                      (attr_byte_in[3] ? 4'hF : 4'h7);
    assign pix_sel = mode_reg[`ATC_MODE_GFX] ? pix_idx_in :
                     mode_reg[`ATC_MODE_MONO] ? mono_idx : txt_idx;
    assign pal_col = {colour_sel_in[3:2],
                      mode_reg[`ATC_MODE_UPPER_SRC] ? colour_sel_in[1:0] :
                      pal_reg[pix_sel][5:4],
                      pal_reg[pix_sel][3:0]};
    assign col_next = !pal_src_on ? 8'h00 :
                      mode_reg[`ATC_MODE_PIX256] ?
                      {nib_reg, pix_idx_in} : pal_col;

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_dot_reg <= 1'b0;
            half_reg     <= 1'b0;
            nib_reg      <= 4'h0;
        end else begin
            prev_dot_reg <= glyph_dot_in;
            half_reg     <= mode_reg[`ATC_MODE_PIX256] & ~half_reg;
            nib_reg      <= pix_idx_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            colour_out     <= 8'h00;
            colour_vld_out <= 1'b0;
        end else begin
            // In 256-colour mode a word lands every second dot
            if (!mode_reg[`ATC_MODE_PIX256] || half_reg) begin
                colour_out <= col_next;
            end
            colour_vld_out <= !mode_reg[`ATC_MODE_PIX256] || half_reg;
        end
    end

    assign video_en_out = pal_src_on;

    // Line compare match and vsync together: vsync wins, flag ends
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pan_zero_reg <= 1'b0;
        end else begin
            pan_zero_reg <= !vsync_in && mode_reg[`ATC_MODE_PAN_RST] &&
                            (line_cmp_in || pan_zero_reg);
        end
    end
    assign pan_out = pan_zero_reg ? 4'h0 : pan_in;

    // ==========================================================
    // Assertions
    a_stat_clears_ff: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in) rd_stat |=> acc_reg == ATC_ACC_INDEX)
        else $error("status read did not clear access flip-flop");
    a_data_store: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in)
        data_wr && sel == `ATC_IDX_MODE |=> mode_reg == $past(io_wdata_in))
        else $error("mode write not stored");
    a_ff_toggle: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in)
        wr_attr && !rd_stat |=> acc_reg != $past(acc_reg))
        else $error("access flip-flop failed to toggle");
    a_ff_hold_rd: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in)
        rd_data && !wr_attr |=> $stable(acc_reg))
        else $error("data read changed access flip-flop");
    a_index_read: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in)
        rd_index |=> io_rdata_out == $past(index_reg))
        else $error("index read returned wrong value");
    a_pal_read: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in)
        rd_data && !sel[4] |=> io_rdata_out[7:6] == 2'b00)
        else $error("palette reserved bits not zero");
    a_blank_src_off: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in)
        !pal_src_on && !mode_reg[`ATC_MODE_PIX256] |=> colour_out == 8'h00)
        else $error("colour not blanked with source bit clear");
    a_pan_forced: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in)
        line_cmp_in && !vsync_in && mode_reg[`ATC_MODE_PAN_RST]
        ##1 !vsync_in |-> pan_out == 4'h0)
        else $error("panning not forced to zero");
    a_half_rate: assert property (@(posedge core_clk_in)
        disable iff (!rst_b_in)
        colour_vld_out && mode_reg[`ATC_MODE_PIX256] &&
        $past(mode_reg[`ATC_MODE_PIX256]) |=> !colour_vld_out)
        else $error("256-colour words not at half rate");
endmodule : atc_attr_ctrl

// File: logic/atc_defs.svh
// Port addresses, field positions and reset values of the attribute stage
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH
`define ATC_PORT_ATTR_WR     10'h3C0
`define ATC_PORT_ATTR_RD     10'h3C1
`define ATC_PORT_STAT_MONO   10'h3BA
`define ATC_PORT_STAT_COLOUR 10'h3DA
`define ATC_IDX_MODE         5'h10
`define ATC_IDX_BITS         4:0
`define ATC_IDX_PAL_SRC      5
`define ATC_IDX_RESET        8'h00
`define ATC_MODE_RESET       8'h00
`define ATC_MODE_UPPER_SRC   7
`define ATC_MODE_PIX256      6
`define ATC_MODE_PAN_RST     5
`define ATC_MODE_BLINK       3
`define ATC_MODE_LINE_GFX    2
`define ATC_MODE_MONO        1
`define ATC_MODE_GFX         0
`define ATC_PAL_MASK         8'h3F
`define ATC_LGFX_FIRST       8'hC0
`define ATC_LGFX_LAST        8'hDF
`define ATC_STAT_VSYNC       3
`endif

// File: logic/atc_pkg.sv
// Types shared by the attribute stage
package atc_pkg;
    typedef enum logic [0:0] {
        ATC_ACC_INDEX = 1'b0,
        ATC_ACC_DATA  = 1'b1
    } atc_acc_t;
endpackage : atc_pkg

// File: bench/atc_host_model.sv
// Host CPU model issuing single legacy I/O port cycles
`timescale 1ns/1ps
module atc_host_model (
    input  wire logic       clk_in,    // Dot clock
    output logic      [9:0] addr_out,  // Port address
    output logic            wr_out,    // Write strobe
    output logic            rd_out,    // Read strobe
    output logic      [7:0] wdata_out, // Write data
    input  wire logic [7:0] rdata_in   // Read data
);
    initial begin
        addr_out = 10'h000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    // ==========================================
    // Bus cycles
    // Released lines park on inverted values so stale data never matches
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        addr_out = ~a;
        @(negedge clk_in);
        d = rdata_in;
    endtask : rd
endmodule : atc_host_model

// File: bench/tb_top.sv
// Self-checking bench of the attribute stage
`timescale 1ns/1ps
`include "atc_defs.svh"
module tb_top;
    logic       clk = 1'b0, rst_b = 1'b0, io_wr, io_rd, glyph, ninth, blink;
    logic       line_cmp = 1'b0, vsync = 1'b0, colour_vld, video_en;
    logic [9:0] io_addr;
    logic [7:0] io_wdata, io_rdata, char_code, attr_byte, colour, d, m;
    logic [3:0] pix = 4'h0, csel = 4'h0, pan = 4'h0, pan_o;
    logic [1:0] smux = 2'h0;
    logic [7:0] pal [16];
    logic [3:0] ti, pp;
    logic       pg;
    int         error_cnt = 0, comparisons = 0, cyc = 0;
    always #25 clk = ~clk;
    atc_host_model atc_host_model_inst (.clk_in(clk), .addr_out(io_addr),
        .wr_out(io_wr), .rd_out(io_rd), .wdata_out(io_wdata),
        .rdata_in(io_rdata));
    atc_attr_ctrl atc_attr_ctrl_inst (.core_clk_in(clk), .rst_b_in(rst_b),
        .io_addr_in(io_addr), .io_wr_in(io_wr), .io_rd_in(io_rd),
        .io_wdata_in(io_wdata), .io_rdata_out(io_rdata), .pix_idx_in(pix),
        .glyph_dot_in(glyph), .ninth_dot_in(ninth), .char_code_in(char_code),
        .attr_byte_in(attr_byte), .blink_on_in(blink), .colour_sel_in(csel),
        .stat_mux_in(smux), .pan_in(pan), .line_cmp_in(line_cmp),
        .vsync_in(vsync), .colour_out(colour), .colour_vld_out(colour_vld),
        .video_en_out(video_en), .pan_out(pan_o));
    // ==========================================
    // Text inputs stay busy though graphics mode ignores them
    always @(negedge clk) begin
        {glyph, ninth, blink} <= 3'($urandom);
        {char_code, attr_byte} <= 16'($urandom);
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Status read first so the next 3C0h write is an index
    task automatic set_reg(input logic [4:0] i, input logic [7:0] v);
        atc_host_model_inst.rd(`ATC_PORT_STAT_COLOUR, d);
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, {3'b001, i});
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, v);
    endtask : set_reg
    task automatic get_reg(input logic [4:0] i);
        atc_host_model_inst.rd(`ATC_PORT_STAT_MONO, d);
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, {3'b001, i});
        atc_host_model_inst.rd(`ATC_PORT_ATTR_RD, d);
    endtask : get_reg
    function automatic logic [7:0] exp_col(logic [7:0] p, md, logic [3:0] c);
        if (md[`ATC_MODE_UPPER_SRC]) return {c, p[3:0]};
        return {c[3:2], p[5:0]};
    endfunction : exp_col
    function automatic logic [1:0] mux_bits(logic [7:0] c, logic [1:0] s);
        case (s)
            2'h0: return {c[2], c[0]};
            2'h1: return {c[5], c[4]};
            2'h2: return {c[3], c[1]};
            default: return {c[7], c[7]};
        endcase
    endfunction : mux_bits
    // Text palette index from dot, ninth column, code and attribute
    function automatic logic [3:0] exp_txt(logic [7:0] md, cc, ab,
                                           logic g, nd, pd, bl);
        logic fg;
        fg = !nd ? g : (md[`ATC_MODE_LINE_GFX] && cc >= `ATC_LGFX_FIRST &&
                        cc <= `ATC_LGFX_LAST) ? pd : 1'b0;
        if (md[`ATC_MODE_MONO]) return fg ? (ab[3] ? 4'hF : 4'h7) : 4'h0;
        if (!fg || (md[`ATC_MODE_BLINK] && ab[7] && bl))
            return md[`ATC_MODE_BLINK] ? {1'b0, ab[6:4]} : ab[7:4];
        return ab[3:0];
    endfunction : exp_txt
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'hA64D));
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        atc_host_model_inst.rd(`ATC_PORT_STAT_COLOUR, d);
        atc_host_model_inst.rd(`ATC_PORT_ATTR_WR, d);
        chk(d, `ATC_IDX_RESET, "index reset");
        get_reg(`ATC_IDX_MODE);
        chk(d, `ATC_MODE_RESET, "mode reset");
        for (int i = 0; i < 16; i++) begin
            pal[i] = 8'($urandom);
            set_reg(5'(i), pal[i]);
        end
        for (int i = 0; i < 16; i++) begin
            get_reg(5'(i));
            chk(d, pal[i] & `ATC_PAL_MASK, "palette");
        end
        atc_host_model_inst.rd(`ATC_PORT_STAT_COLOUR, d);
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, 8'h23);
        atc_host_model_inst.rd(`ATC_PORT_ATTR_RD, d);
        atc_host_model_inst.rd(`ATC_PORT_ATTR_RD, d);
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, 8'h05);
        atc_host_model_inst.rd(`ATC_PORT_ATTR_WR, d);
        chk(d, 8'h23, "index after data");
        pal[3] = 8'h05;
        get_reg(5'h03);
        chk(d, 8'h05, "data after reads");
        // First 24h is palette 3 data, second leaves the flip-flop on data
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, 8'h24);
        pal[3] = 8'h24;
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, 8'h24);
        atc_host_model_inst.rd(`ATC_PORT_STAT_MONO, d);
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, 8'h26);
        atc_host_model_inst.rd(`ATC_PORT_ATTR_WR, d);
        chk(d, 8'h26, "status clear");
        set_reg(5'h11, 8'hFF);
        get_reg(5'h11);
        chk(d, 8'h00, "unused index");
        for (int n = 0; n < 12; n++) begin
            m = (8'($urandom) & 8'hA0) | 8'h01;
            set_reg(`ATC_IDX_MODE, m);
            get_reg(`ATC_IDX_MODE);
            chk(d, m, "mode rd");
            pix = 4'($urandom);
            csel = 4'($urandom);
            smux = 2'(n);
            repeat (3) @(negedge clk);
            chk(colour, exp_col(pal[pix], m, csel), "colour");
            chk({7'h00, video_en}, 8'h01, "video on");
            atc_host_model_inst.rd(`ATC_PORT_STAT_COLOUR, d);
            chk({6'h00, d[5:4]}, {6'h00, mux_bits(colour, smux)},
                "mux");
        end
        // ==========================================
        // Text modes: random blink, line graphics, mono and upper source
        for (int n = 0; n < 8; n++) begin
            m = 8'($urandom) & 8'h8E;
            set_reg(`ATC_IDX_MODE, m);
            csel = 4'($urandom);
            @(posedge clk);
            pg = glyph;
            repeat (16) begin
                @(posedge clk);
                ti = exp_txt(m, char_code, attr_byte, glyph, ninth, pg, blink);
                pg = glyph;
                @(negedge clk);
                chk(colour, exp_col(pal[ti], m, csel),
                    "text");
            end
        end
        // 256-colour: nibble pairs, a word every second dot
        set_reg(`ATC_IDX_MODE, 8'h41);
        pp = 4'h0;
        for (int k = 1; k <= 16; k++) begin
            pix = 4'($urandom);
            @(negedge clk);
            chk({7'h00, colour_vld}, {7'h00, ~k[0]}, "half rate");
            if (k[0] == 1'b0) chk(colour, {pp, pix}, "256 word");
            pp = pix;
        end
        for (int k = 0; k < 2; k++) begin
            set_reg(`ATC_IDX_MODE, k ? 8'h01 : 8'h21);
            pan = 4'($urandom) | 4'h1;
            @(negedge clk);
            line_cmp = 1'b1;
            @(negedge clk);
            line_cmp = 1'b0;
            repeat (2) @(negedge clk);
            chk({4'h0, pan_o}, k ? {4'h0, pan} : 8'h00, "pan cut");
            vsync = 1'b1;
            repeat (2) @(negedge clk);
            vsync = 1'b0;
            chk({4'h0, pan_o}, {4'h0, pan}, "pan back");
        end
        atc_host_model_inst.rd(`ATC_PORT_STAT_COLOUR, d);
        atc_host_model_inst.wr(`ATC_PORT_ATTR_WR, 8'h10);
        repeat (3) @(negedge clk);
        chk({7'h00, video_en}, 8'h00, "video off");
        chk(colour, 8'h00, "blank colour");
        wrap_up();
    end
endmodule : tb_top
